// File: verilog/scr_pkg.sv
/*
 * Constants for the synthesizer core control register group: register
 * offsets, field positions, write masks, reset values and calibration timing.
 * Assumes a 16-bit register port with a 7-bit word address.
 */
package scr_pkg;
   // ****************************************************************
   // Register word addresses.
   // ****************************************************************
   localparam logic [6:0] ADDR_MAIN = 7'h00;
   localparam logic [6:0] ADDR_DIV = 7'h01;
   localparam logic [6:0] ADDR_FORCE = 7'h08;
   localparam logic [6:0] ADDR_DBL = 7'h09;
   localparam logic [6:0] ADDR_CUR = 7'h10;
   localparam logic [6:0] ADDR_BAND = 7'h13;
   localparam logic [6:0] ADDR_STAT = 7'h20;

   // ****************************************************************
   // Field positions.
   // ****************************************************************
   localparam int POS_SYNC = 14;
   localparam int POS_MUTE = 9;
   localparam int POS_ADJ = 7;
   localparam int POS_CAL = 3;
   localparam int POS_SEL = 2;
   localparam int POS_SRST = 1;
   localparam int POS_SLEEP = 0;
   localparam int POS_CUR_FRC = 14;
   localparam int POS_BAND_FRC = 11;
   localparam int POS_DBL = 12;

   // ****************************************************************
   // Writable bit masks and values after reset.
   // ****************************************************************
   localparam logic [15:0] MASK_MAIN = 16'h438f;
   localparam logic [15:0] MASK_DIV = 16'h0007;
   localparam logic [15:0] MASK_FORCE = 16'h4800;
   localparam logic [15:0] MASK_DBL = 16'h1000;
   localparam logic [15:0] MASK_CUR = 16'h01ff;
   localparam logic [15:0] MASK_BAND = 16'h00ff;
   localparam logic [15:0] RST_MAIN = 16'h000c;
   localparam logic [15:0] RST_DIV = 16'h0004;
   localparam logic [15:0] RST_FORCE = 16'h0000;
   localparam logic [15:0] RST_DBL = 16'h0000;
   localparam logic [15:0] RST_CUR = 16'h0080;
   localparam logic [15:0] RST_BAND = 16'h00b7;

   // ****************************************************************
   // Calibration length in state machine clock ticks.
   // ****************************************************************
   localparam logic [7:0] CAL_TICKS = 8'h10;

   typedef enum logic [0:0] {CAL_IDLE, CAL_RUN} scr_cal_e;
endpackage : scr_pkg

// File: verilog/scr_tick_gen.sv
/*
 * State machine clock tick generator: one pulse every 2^(div+adj) cycles.
 * Assumes the system clock stands in for the reference input.
 */
`timescale 1ns/1ps
module scr_tick_gen (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Control
   input wire logic run_i,
   input wire logic [2:0] div_i,
   input wire logic [1:0] adj_i,
   // Tick out
   output logic tick_o
);
   logic [10:0] cnt_r;
   wire [3:0] shift = {1'b0, div_i} + {2'b00, adj_i};
   wire [10:0] ratio = 11'h001 << shift;
   wire hit = (cnt_r == ratio - 11'h001);

   assign tick_o = run_i & hit;

   always_ff @(posedge clk_i) begin
      if (!nrst_i || !run_i || hit) begin
         cnt_r <= 11'h000;
      end else begin
         cnt_r <= cnt_r + 11'h001;
      end
   end
endmodule : scr_tick_gen

// File: verilog/scr_cal_fsm.sv
/*
 * Calibration sequencer: runs a fixed number of ticks, then captures the
 * band and current found by the analog search.
 * Assumes the search results on its inputs are stable at the last tick.
 */
`timescale 1ns/1ps
module scr_cal_fsm (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Control
   input wire logic start_i,
   input wire logic tick_i,
   // Search results
   input wire logic [7:0] band_i,
   input wire logic [8:0] cur_i,
   // Status and results
   output logic busy_o,
   output logic done_o,
   output logic [7:0] band_o,
   output logic [8:0] cur_o
);
   scr_pkg::scr_cal_e state_r;
   logic [7:0] cnt_r;
   wire last = tick_i && (cnt_r == scr_pkg::CAL_TICKS - 8'h01);

   assign busy_o = (state_r == scr_pkg::CAL_RUN);

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         state_r <= scr_pkg::CAL_IDLE;
         cnt_r <= 8'h00;
         done_o <= 1'b0;
         band_o <= scr_pkg::RST_BAND[7:0];
         cur_o <= scr_pkg::RST_CUR[8:0];
      end else begin
         done_o <= 1'b0;
         unique case (state_r)
            scr_pkg::CAL_IDLE: begin
               cnt_r <= 8'h00;
               if (start_i) begin
                  state_r <= scr_pkg::CAL_RUN;
               end
            end
            scr_pkg::CAL_RUN: begin
               // A new trigger restarts the search.
               if (start_i) begin
                  cnt_r <= 8'h00;
               end else if (last) begin
                  state_r <= scr_pkg::CAL_IDLE;
                  done_o <= 1'b1;
                  band_o <= band_i;
                  cur_o <= cur_i;
               end else if (tick_i) begin
                  cnt_r <= cnt_r + 8'h01;
               end
            end
         endcase
      end
   end
endmodule : scr_cal_fsm

// File: verilog/scr_core.sv
/*
 * Synthesizer core control registers with calibration sequencing,
 * phase-sync pulse, output muting, status pin select and VCO overrides.
 * Assumes a register master on the plain port whose strobes are one cycle
 * long and never both high, and synchronous inputs from the analog side.
 */
`timescale 1ns/1ps
module scr_core (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Register port
   input wire logic [6:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic we_i,
   input wire logic re_i,
   output logic [15:0] rdata_o,
   // Analog side inputs
   input wire logic lock_detect_i,
   input wire logic readback_bit_i,
   input wire logic [7:0] cal_band_i,
   input wire logic [8:0] cal_cur_i,
   // Control outputs
   output logic phase_sync_mode_o,
   output logic sync_pulse_o,
   output logic rf_mute_o,
   output logic sleep_o,
   output logic ref_doubler_o,
   output logic mux_pin_o,
   output logic cal_busy_o,
   output logic [7:0] vco_band_o,
   output logic [8:0] vco_cur_o
);
   // ****************************************************************
   // Register storage.
   // ****************************************************************
   logic [15:0] main_r;
   logic [15:0] div_r;
   logic [15:0] force_r;
   logic [15:0] dbl_r;
   logic [15:0] cur_r;
   logic [15:0] band_r;
   logic [15:0] main_nxt;
   logic sync_prev_r;

   // ****************************************************************
   // Decode.
   // ****************************************************************
   wire wr_main = we_i && (addr_i == scr_pkg::ADDR_MAIN);
   wire wr_div = we_i && (addr_i == scr_pkg::ADDR_DIV);
   wire wr_force = we_i && (addr_i == scr_pkg::ADDR_FORCE);
   wire wr_dbl = we_i && (addr_i == scr_pkg::ADDR_DBL);
   wire wr_cur = we_i && (addr_i == scr_pkg::ADDR_CUR);
   wire wr_band = we_i && (addr_i == scr_pkg::ADDR_BAND);
   wire soft_rst = main_r[scr_pkg::POS_SRST];
   wire core_nrst = nrst_i && !soft_rst;
   wire wr_srst = wdata_i[scr_pkg::POS_SRST];
   wire cal_start = wr_main && wdata_i[scr_pkg::POS_CAL] && !wr_srst && !soft_rst;
   wire cal_busy;
   wire cal_done;
   wire cal_tick;
   wire [7:0] cal_band;
   wire [8:0] cal_cur;
   wire [15:0] stat_word = {14'h0000, lock_detect_i, cal_busy};
   wire sync_bit = main_r[scr_pkg::POS_SYNC];

   // While soft reset is written, every other field returns to its reset value.
   assign main_nxt = wr_srst ? (scr_pkg::RST_MAIN | (16'h0001 << scr_pkg::POS_SRST))
                             : (wdata_i & scr_pkg::MASK_MAIN);

   wire [15:0] rd_mux =
      (addr_i == scr_pkg::ADDR_MAIN) ? main_r :
      (addr_i == scr_pkg::ADDR_DIV) ? div_r :
      (addr_i == scr_pkg::ADDR_FORCE) ? force_r :
      (addr_i == scr_pkg::ADDR_DBL) ? dbl_r :
      (addr_i == scr_pkg::ADDR_CUR) ? cur_r :
      (addr_i == scr_pkg::ADDR_BAND) ? band_r :
      (addr_i == scr_pkg::ADDR_STAT) ? stat_word : 16'h0000;

   // ****************************************************************
   // Main control register, held apart from soft reset.
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         main_r <= scr_pkg::RST_MAIN;
      end else if (wr_main) begin
         main_r <= main_nxt;
      end
   end

   // ****************************************************************
   // Other registers, all loaded with their reset values while soft reset is held.
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (!core_nrst) begin
         div_r <= scr_pkg::RST_DIV;
      end else if (wr_div) begin
         div_r <= wdata_i & scr_pkg::MASK_DIV;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!core_nrst) begin
         force_r <= scr_pkg::RST_FORCE;
      end else if (wr_force) begin
         force_r <= wdata_i & scr_pkg::MASK_FORCE;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!core_nrst) begin
         dbl_r <= scr_pkg::RST_DBL;
      end else if (wr_dbl) begin
         dbl_r <= wdata_i & scr_pkg::MASK_DBL;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!core_nrst) begin
         cur_r <= scr_pkg::RST_CUR;
      end else if (wr_cur) begin
         cur_r <= wdata_i & scr_pkg::MASK_CUR;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!core_nrst) begin
         band_r <= scr_pkg::RST_BAND;
      end else if (wr_band) begin
         band_r <= wdata_i & scr_pkg::MASK_BAND;
      end
   end

   // ****************************************************************
   // Read port: data one cycle after the strobe, zero otherwise.
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (!nrst_i || !re_i) begin
         rdata_o <= 16'h0000;
      end else begin
         rdata_o <= rd_mux;
      end
   end

   // ****************************************************************
   // Calibration clock and sequencer.
   // ****************************************************************
   scr_tick_gen u_tick (
      .clk_i (clk_i),
      .nrst_i (core_nrst),
      .run_i (cal_busy),
      .div_i (div_r[2:0]),
      .adj_i (main_r[scr_pkg::POS_ADJ +: 2]),
      .tick_o (cal_tick)
   );

   scr_cal_fsm u_cal (
      .clk_i (clk_i),
      .nrst_i (core_nrst),
      .start_i (cal_start),
      .tick_i (cal_tick),
      .band_i (cal_band_i),
      .cur_i (cal_cur_i),
      .busy_o (cal_busy),
      .done_o (cal_done),
      .band_o (cal_band),
      .cur_o (cal_cur)
   );

   assign cal_busy_o = cal_busy;

   // ****************************************************************
   // Registered control outputs.
   // ****************************************************************
   wire pulse_nxt = sync_bit && !sync_prev_r;
   wire mute_nxt = main_r[scr_pkg::POS_MUTE] && cal_busy;
   wire pin_nxt = main_r[scr_pkg::POS_SEL] ? lock_detect_i : readback_bit_i;
   wire band_frc = force_r[scr_pkg::POS_BAND_FRC];
   wire cur_frc = force_r[scr_pkg::POS_CUR_FRC];
   // A forced band outside the legal range is passed on unchecked.
   wire [7:0] band_nxt = band_frc ? band_r[7:0] : cal_band;
   wire [8:0] cur_nxt = cur_frc ? cur_r[8:0] : cal_cur;

   // The detector resets to the idle low level of the mode bit, so no false pulse follows a reset.
   always_ff @(posedge clk_i) begin
      if (!core_nrst) begin
         sync_prev_r <= 1'b0;
         sync_pulse_o <= 1'b0;
      end else begin
         sync_prev_r <= sync_bit;
         sync_pulse_o <= pulse_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!core_nrst) begin
         phase_sync_mode_o <= 1'b0;
      end else begin
         phase_sync_mode_o <= sync_bit;
      end
   end

   // Muting trails the busy flag by one cycle, as the other outputs do.
   always_ff @(posedge clk_i) begin
      if (!core_nrst) begin
         rf_mute_o <= 1'b0;
      end else begin
         rf_mute_o <= mute_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!core_nrst) begin
         sleep_o <= 1'b0;
      end else begin
         sleep_o <= main_r[scr_pkg::POS_SLEEP];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!core_nrst) begin
         ref_doubler_o <= 1'b0;
      end else begin
         ref_doubler_o <= dbl_r[scr_pkg::POS_DBL];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!core_nrst) begin
         mux_pin_o <= 1'b0;
      end else begin
         mux_pin_o <= pin_nxt;
      end
   end

   // Results stay held after calibration, so releasing a force shows them at once.
   always_ff @(posedge clk_i) begin
      if (!core_nrst) begin
         vco_band_o <= scr_pkg::RST_BAND[7:0];
         vco_cur_o <= scr_pkg::RST_CUR[8:0];
      end else begin
         vco_band_o <= band_nxt;
         vco_cur_o <= cur_nxt;
      end
   end

   // ****************************************************************
   // Assertions.
   // ****************************************************************
   a_sync_edge: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (core_nrst && sync_bit && !sync_prev_r) |=> sync_pulse_o)
      else $error("sync pulse missing after phase-sync rise");

   a_sync_single: assert property (@(posedge clk_i) disable iff (!nrst_i)
      sync_pulse_o |=> !sync_pulse_o)
      else $error("sync pulse longer than one cycle");

   a_sync_mode: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (core_nrst && $past(core_nrst) && sync_bit) |=> phase_sync_mode_o)
      else $error("phase-sync mode not driven");

   a_mute_cal: assert property (@(posedge clk_i) disable iff (!nrst_i)
      rf_mute_o |-> ($past(cal_busy) && $past(main_r[scr_pkg::POS_MUTE])))
      else $error("mute outside calibration or without mute bit");

   a_mute_during: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (core_nrst && cal_busy && main_r[scr_pkg::POS_MUTE]) |=> (rf_mute_o || !core_nrst))
      else $error("outputs not muted during calibration");

   a_cal_trigger: assert property (@(posedge clk_i) disable iff (!nrst_i)
      cal_start |=> cal_busy [*2])
      else $error("calibration not started by main write");

   a_cal_ends: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (cal_start && div_r[2:0] == 3'h0 && wdata_i[scr_pkg::POS_ADJ +: 2] == 2'h0)
      ##1 (!we_i [*8]) ##1 (!we_i [*8])
      |-> ##[0:2] cal_done)
      else $error("fast calibration did not finish in time");

   a_status_pin: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (core_nrst && !main_r[scr_pkg::POS_SEL]) |=> (mux_pin_o == $past(readback_bit_i) || !core_nrst))
      else $error("status pin not showing readback");

   a_soft_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
      soft_rst |=> (div_r == scr_pkg::RST_DIV && !cal_busy && force_r == scr_pkg::RST_FORCE))
      else $error("registers not held in soft reset");

   a_soft_sticky: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (soft_rst && !wr_main) |=> soft_rst)
      else $error("soft reset cleared itself");

   a_band_force: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (core_nrst && force_r[scr_pkg::POS_BAND_FRC] && !wr_band && !we_i) |=> ##1
      (vco_band_o == $past(band_r[7:0], 2) || !core_nrst))
      else $error("forced band not applied");

   a_cur_force: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (core_nrst && force_r[scr_pkg::POS_CUR_FRC]) |=> (vco_cur_o == $past(cur_r[8:0]) || !core_nrst))
      else $error("forced current not applied");

   a_div_reset: assert property (@(posedge clk_i)
      !nrst_i |=> (div_r == scr_pkg::RST_DIV && main_r == scr_pkg::RST_MAIN))
      else $error("wrong reset values");

   a_read_latency: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (re_i && addr_i == scr_pkg::ADDR_DIV) |=> (rdata_o == $past(div_r)))
      else $error("read data wrong or late");

   a_read_idle: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !re_i |=> (rdata_o == 16'h0000))
      else $error("read data not zero outside a read");

   a_stat_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (re_i && addr_i == scr_pkg::ADDR_STAT) |=> (rdata_o[1] == $past(lock_detect_i)))
      else $error("status read does not show lock detect");

   a_sleep_pin: assert property (@(posedge clk_i) disable iff (!nrst_i)
      core_nrst |=> (sleep_o == $past(main_r[scr_pkg::POS_SLEEP])))
      else $error("sleep output does not follow its bit");

   a_doubler_pin: assert property (@(posedge clk_i) disable iff (!nrst_i)
      core_nrst |=> (ref_doubler_o == $past(dbl_r[scr_pkg::POS_DBL])))
      else $error("doubler output does not follow its bit");

   a_mute_idle: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !cal_busy |=> !rf_mute_o)
      else $error("outputs muted outside calibration");

   a_band_cal: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (core_nrst && !force_r[scr_pkg::POS_BAND_FRC]) |=> (vco_band_o == $past(cal_band)))
      else $error("calibrated band not applied");

   a_cur_cal: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (core_nrst && !force_r[scr_pkg::POS_CUR_FRC]) |=> (vco_cur_o == $past(cal_cur)))
      else $error("calibrated current not applied");

   a_srst_main: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (wr_main && wr_srst) |=> (main_r == (scr_pkg::RST_MAIN | (16'h0001 << scr_pkg::POS_SRST))))
      else $error("soft reset write did not restore main fields");

   c_cal_done: cover property (@(posedge clk_i) disable iff (!nrst_i) cal_done);
   c_sync: cover property (@(posedge clk_i) disable iff (!nrst_i) sync_pulse_o);
   c_mute: cover property (@(posedge clk_i) disable iff (!nrst_i) rf_mute_o);
   c_force: cover property (@(posedge clk_i) disable iff (!nrst_i) force_r[scr_pkg::POS_BAND_FRC]);
   c_soft: cover property (@(posedge clk_i) disable iff (!nrst_i) soft_rst ##1 !soft_rst);
endmodule : scr_core

// File: sim/test_scr_core.sv
/*
 * Self-checking testbench for the core control register group.
 * Assumes the design package is compiled first and a 20 MHz clock.
 */
`timescale 1ns/1ps
module test_scr_core;
   logic clk_i, nrst_i, we_i, re_i, lock_detect_i, readback_bit_i;
   logic [6:0] addr_i;
   logic [15:0] wdata_i, rdata_o;
   logic [7:0] cal_band_i, vco_band_o;
   logic [8:0] cal_cur_i, vco_cur_o;
   logic phase_sync_mode_o, sync_pulse_o, rf_mute_o, sleep_o, ref_doubler_o, mux_pin_o, cal_busy_o;
   int n_errors, tests_run, cycles;

   scr_core u_scr_core (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
      .re_i(re_i), .rdata_o(rdata_o), .lock_detect_i(lock_detect_i), .readback_bit_i(readback_bit_i),
      .cal_band_i(cal_band_i), .cal_cur_i(cal_cur_i), .phase_sync_mode_o(phase_sync_mode_o),
      .sync_pulse_o(sync_pulse_o), .rf_mute_o(rf_mute_o), .sleep_o(sleep_o), .ref_doubler_o(ref_doubler_o),
      .mux_pin_o(mux_pin_o), .cal_busy_o(cal_busy_o), .vco_band_o(vco_band_o), .vco_cur_o(vco_cur_o));

   // ****************************************************************
   // Clock, timeout and bus tasks.
   // ****************************************************************
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   // The whole run needs well under two thousand cycles.
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_errors = n_errors + 1;
         complete_run();
      end
   end

   task automatic complete_run();
      if (n_errors == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         n_errors = n_errors + 1;
      end
   endtask : chk

   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      we_i <= 1'b1;
      @(posedge clk_i);
      we_i <= 1'b0;
   endtask : wr

   task automatic rdchk(input logic [6:0] a, input logic [15:0] exp);
      @(posedge clk_i);
      addr_i <= a;
      re_i <= 1'b1;
      @(posedge clk_i);
      re_i <= 1'b0;
      #1;
      chk(rdata_o, exp);
   endtask : rdchk

   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : idle

   // ****************************************************************
   // Scenarios.
   // ****************************************************************
   task automatic t_reset_values();
      rdchk(scr_pkg::ADDR_MAIN, 16'h000c);
      rdchk(scr_pkg::ADDR_DIV, 16'h0004);
      rdchk(scr_pkg::ADDR_FORCE, 16'h0000);
      rdchk(scr_pkg::ADDR_CUR, 16'h0080);
      rdchk(scr_pkg::ADDR_BAND, 16'h00b7);
      chk(16'(vco_band_o), 16'h00b7);
      chk(16'(vco_cur_o), 16'h0080);
      wr(7'h05, 16'hffff);
      rdchk(7'h05, 16'h0000);
      wr(scr_pkg::ADDR_DIV, 16'hffff);
      rdchk(scr_pkg::ADDR_DIV, 16'h0007);
      wr(scr_pkg::ADDR_STAT, 16'hffff);
      rdchk(scr_pkg::ADDR_STAT, 16'h0002);
   endtask : t_reset_values

   task automatic t_pins();
      wr(scr_pkg::ADDR_MAIN, 16'h0005);
      lock_detect_i <= 1'b0;
      readback_bit_i <= 1'b1;
      idle(3);
      chk(16'(mux_pin_o), 16'h0000);
      chk(16'(sleep_o), 16'h0001);
      @(posedge clk_i);
      lock_detect_i <= 1'b1;
      idle(3);
      chk(16'(mux_pin_o), 16'h0001);
      wr(scr_pkg::ADDR_MAIN, 16'h0000);
      readback_bit_i <= 1'b0;
      idle(3);
      chk(16'(mux_pin_o), 16'h0000);
      @(posedge clk_i);
      readback_bit_i <= 1'b1;
      idle(3);
      chk(16'(mux_pin_o), 16'h0001);
      wr(scr_pkg::ADDR_DBL, 16'hffff);
      rdchk(scr_pkg::ADDR_DBL, 16'h1000);
      chk(16'(ref_doubler_o), 16'h0001);
   endtask : t_pins

   task automatic t_sync(input logic [15:0] exp_pulses);
      int n;
      n = 0;
      wr(scr_pkg::ADDR_MAIN, 16'h4000);
      for (int i = 0; i < 6; i++) begin
         @(posedge clk_i);
         #1;
         if (sync_pulse_o === 1'b1) n++;
      end
      chk(16'(n), exp_pulses);
      chk(16'(phase_sync_mode_o), 16'h0001);
   endtask : t_sync

   task automatic t_cal(input logic [15:0] main_v, input int lo, input int hi, input logic mute_exp);
      int n;
      logic mute;
      n = 1;
      mute = 1'b0;
      wr(scr_pkg::ADDR_MAIN, main_v);
      // Busy rises at the edge that takes the write, so that cycle is counted here.
      #1;
      chk(16'(cal_busy_o), 16'h0001);
      for (int i = 0; i < 400; i++) begin
         @(posedge clk_i);
         #1;
         if (rf_mute_o === 1'b1) mute = 1'b1;
         if (cal_busy_o !== 1'b1) break;
         n++;
      end
      chk(16'(n >= lo && n <= hi), 16'h0001);
      chk(16'(mute), 16'(mute_exp));
      idle(3);
      chk(16'(rf_mute_o), 16'h0000);
      chk(16'(vco_band_o), 16'(cal_band_i));
      chk(16'(vco_cur_o), 16'(cal_cur_i));
   endtask : t_cal

   task automatic t_force();
      wr(scr_pkg::ADDR_BAND, 16'h0021);
      wr(scr_pkg::ADDR_CUR, 16'h01a5);
      wr(scr_pkg::ADDR_FORCE, 16'hffff);
      rdchk(scr_pkg::ADDR_FORCE, 16'h4800);
      idle(3);
      chk(16'(vco_band_o), 16'h0021);
      chk(16'(vco_cur_o), 16'h01a5);
      wr(scr_pkg::ADDR_FORCE, 16'h0800);
      idle(3);
      chk(16'(vco_cur_o), 16'(cal_cur_i));
      chk(16'(vco_band_o), 16'h0021);
   endtask : t_force

   task automatic t_soft_reset();
      wr(scr_pkg::ADDR_MAIN, 16'h4202);
      wr(scr_pkg::ADDR_DIV, 16'h0003);
      idle(3);
      rdchk(scr_pkg::ADDR_MAIN, 16'h000e);
      rdchk(scr_pkg::ADDR_DIV, 16'h0004);
      rdchk(scr_pkg::ADDR_BAND, 16'h00b7);
      chk(16'(vco_band_o), 16'h00b7);
      chk(16'(phase_sync_mode_o), 16'h0000);
      chk(16'(ref_doubler_o), 16'h0000);
      idle(20);
      rdchk(scr_pkg::ADDR_MAIN, 16'h000e);
      wr(scr_pkg::ADDR_MAIN, 16'h0000);
      wr(scr_pkg::ADDR_DIV, 16'h0002);
      rdchk(scr_pkg::ADDR_DIV, 16'h0002);
   endtask : t_soft_reset

   // ****************************************************************
   // Main sequence.
   // ****************************************************************
   initial begin
      n_errors = 0;
      tests_run = 0;
      cycles = 0;
      nrst_i = 1'b0;
      addr_i = 7'h00;
      wdata_i = 16'h0000;
      we_i = 1'b0;
      re_i = 1'b0;
      lock_detect_i = 1'b1;
      readback_bit_i = 1'b0;
      cal_band_i = 8'h3c;
      cal_cur_i = 9'h155;
      repeat (8) @(posedge clk_i);
      nrst_i <= 1'b1;
      t_reset_values();
      t_pins();
      t_sync(16'h0001);
      t_sync(16'h0000);
      wr(scr_pkg::ADDR_DIV, 16'h0000);
      t_cal(16'h0208, int'(scr_pkg::CAL_TICKS), int'(scr_pkg::CAL_TICKS) + 3, 1'b1);
      @(posedge clk_i);
      cal_band_i <= 8'h5a;
      cal_cur_i <= 9'h0ab;
      t_cal(16'h0088, 2 * int'(scr_pkg::CAL_TICKS), 2 * int'(scr_pkg::CAL_TICKS) + 4, 1'b0);
      wr(scr_pkg::ADDR_DIV, 16'h0001);
      t_cal(16'h0088, 4 * int'(scr_pkg::CAL_TICKS), 4 * int'(scr_pkg::CAL_TICKS) + 6, 1'b0);
      t_force();
      t_soft_reset();
      complete_run();
   end
endmodule : test_scr_core
